// ---- spb_core.sv ----
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// - host normal mode, write during transfer corrupts byte and sets collision flag
// - normal mode received byte lands in receive register at transfer end
// - normal mode sets done flag at completion; irq while flag and enable set
// - buffer mode set by buffer bit in second control register; wait-for-receive ignored as host
// - host buffer: first write starts shifting, next goes to transmit buffer
// - buffer mode received bytes enter two-entry fifo, data reads pop it
// - buffer mode complete flag when shifter and buffer empty; irq if enabled
// - host with select input low becomes client, clears host, sets done flag
// - select disabled or select output: select pin never changes role
// - client normal idles while select high, shifts after low, flags each byte
// - client normal write during transfer is dropped and sets collision flag
// - client with select high halts and drops partial byte
// - client buffer, no wait: writes go to buffer, first byte is dummy
// - client buffer write while buffer full is lost
// - empty flag clears on buffer write, sets when buffer copied to shifter
// - receive flag one clock after empty flag, complete flag one after that
// - client buffer with wait: write while deselected reaches shifter next clock
// - client miso driven only while select low
module spb_core
    import spb_pkg::*;
#(
    parameter int HALF_DIV = SCK_HALF_DEF
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sck_in,
    input  wire logic        ss_n_in,
    input  wire logic        mosi_in,
    input  wire logic        miso_in,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             mosi_out,
    output logic             mosi_oe,
    output logic             miso_out,
    output logic             miso_oe,
    output logic             irq
);
    localparam logic [7:0] DIV_END = 8'(HALF_DIV - 1);

    logic [2:0]  ra_q;
    logic        rd_q, wr_q, map_q;
    logic [7:0]  ctla_q, ctlb_q, intc_q, pdir_q;
    logic [3:0]  s1_q, s2_q;
    logic        sckp_q;
    spb_state_t  st_q;
    logic [7:0]  div_q, sh_q, txb_q, rxd_q, lb_q;
    logic [3:0]  cnt_q;
    logic        out_q, txf_q, ld_q, d1_q, d2_q;
    logic        td_q, wcol_q, rxc_q, txc_q, ovf_q;
    logic [7:0]  rxf_q [2];
    logic [1:0]  rxn_q;

    logic en, host, bufm, buffer_wait_for_receive, seldis, ssn, act, demote, tick;
    logic er, ef, din, done, dwr, busy, pop, push, wr_go, shf;
    logic [7:0] wd, last;

    // ==========================================
    // AHB-Lite slave: writes zero wait, reads one wait for registered data
    function automatic logic [7:0] rd_val(input logic [2:0] idx);
        case (idx)
            IDX_CTLA: rd_val = ctla_q;
            IDX_CTLB: rd_val = ctlb_q;
            IDX_INTC: rd_val = intc_q;
            IDX_FLAG: rd_val = bufm ? {rxc_q, txc_q, !txf_q, 4'h0, ovf_q}
                                    : {td_q, wcol_q, 6'h00};
            IDX_DATA: rd_val = bufm ? rxf_q[0] : rxd_q;
            IDX_PDIR: rd_val = pdir_q;
            default:  rd_val = 8'h00;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ra_q <= 3'h0; rd_q <= 1'b0; wr_q <= 1'b0; map_q <= 1'b0;
            hrdata <= 32'h0000_0000; hreadyout <= 1'b1; hresp <= 1'b0;
        end else if (ce) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            if (rd_q) begin
                hrdata    <= map_q ? {24'h000000, rd_val(ra_q)} : 32'h0000_0000;
                hreadyout <= 1'b1;
            end
            if (hsel && htrans[1] && hready) begin
                ra_q  <= haddr[4:2];
                map_q <= (haddr[31:5] == 27'h0) && (haddr[4:2] <= IDX_PDIR);
                rd_q  <= !hwrite;
                wr_q  <= hwrite;
                if (!hwrite) hreadyout <= 1'b0;
            end
        end
    end

    assign wr_go = wr_q && map_q;
    assign wd    = hwdata[7:0];
    assign dwr   = wr_go && (ra_q == IDX_DATA);
    assign pop   = rd_q && map_q && (ra_q == IDX_DATA) && bufm && (rxn_q != 2'h0);

    // ==========================================
    // pin synchronisers: bit 0 sck, 1 select, 2 mosi, 3 miso
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 4'h2; s2_q <= 4'h2; sckp_q <= 1'b0;
        end else if (ce) begin
            s1_q   <= {miso_in, mosi_in, ss_n_in, sck_in};
            s2_q   <= s1_q;
            sckp_q <= s2_q[0];
        end
    end

    assign en     = ctla_q[B_EN];
    assign host   = ctla_q[B_HOST];
    assign bufm   = ctlb_q[B_BUF];
    assign buffer_wait_for_receive  = ctlb_q[B_WFR] && !host;
    assign seldis = ctlb_q[B_SELDIS];
    assign ssn    = s2_q[1];
    assign demote = en && host && !seldis && !pdir_q[B_SSOUT] && !ssn;
    assign act    = en && !host && !ssn;
    assign tick   = host && (st_q == ST_SHIFT) && (div_q == DIV_END);
    // client edges need each sck phase over two hclk cycles to be seen
    assign er     = host ? (tick && !sck_out) : (act && s2_q[0] && !sckp_q);
    assign ef     = host ? (tick && sck_out) : (act && !s2_q[0] && sckp_q);
    assign din    = host ? s2_q[3] : s2_q[2];
    assign done   = host ? (ef && cnt_q == BITS_BYTE) : (er && cnt_q == 4'h7);
    assign shf    = host ? ef : er;
    assign last   = {sh_q[6:0], din};
    assign busy   = host ? (st_q == ST_SHIFT) : (act && cnt_q != 4'h0);

    // ==========================================
    // control registers; demotion beats a software write of the host bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctla_q <= RST_REG8; ctlb_q <= RST_REG8;
            intc_q <= RST_REG8; pdir_q <= RST_REG8;
        end else if (ce) begin
            if (wr_go && ra_q == IDX_CTLA) ctla_q <= wd;
            if (wr_go && ra_q == IDX_CTLB) ctlb_q <= wd;
            if (wr_go && ra_q == IDX_INTC) intc_q <= wd;
            if (wr_go && ra_q == IDX_PDIR) pdir_q <= wd;
            if (demote) ctla_q[B_HOST] <= 1'b0;
        end
    end

    // ==========================================
    // shifter, host sck generator and transmit buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE; div_q <= 8'h00; sck_out <= 1'b0;
            sh_q <= RST_SHIFT; cnt_q <= 4'h0; out_q <= 1'b0;
            txb_q <= RST_REG8; txf_q <= 1'b0; ld_q <= 1'b0; wcol_q <= 1'b0;
        end else if (ce) begin
            if (wr_go && ra_q == IDX_FLAG && wd[6]) wcol_q <= 1'b0;
            if (tick) begin
                div_q   <= 8'h00;
                sck_out <= !sck_out;
            end else if (st_q == ST_SHIFT) begin
                div_q <= div_q + 8'h01;
            end
            if (er) cnt_q <= cnt_q + 4'h1;
            // host samples synced miso on its falling tick; client readies next bit at once
            if (shf) begin
                sh_q  <= {sh_q[6:0], din};
                out_q <= sh_q[6];
            end
            if (!host && !act) begin
                cnt_q <= 4'h0;
                out_q <= sh_q[7];
            end
            if (done) begin
                cnt_q <= 4'h0;
                if (bufm && txf_q) begin
                    sh_q  <= txb_q;
                    out_q <= txb_q[7];
                    txf_q <= 1'b0;
                    ld_q  <= 1'b1;
                    div_q <= 8'h00;
                end else begin
                    st_q <= ST_IDLE;
                    ld_q <= 1'b0;
                end
            end
            if (dwr && !bufm) begin
                if (busy) begin
                    wcol_q <= 1'b1;
                    // host: new byte lands mid-shift, so the outgoing byte is garbled
                    if (host) sh_q <= wd;
                end else begin
                    sh_q  <= wd;
                    out_q <= wd[7];
                    if (host && en) begin
                        st_q  <= ST_SHIFT;
                        div_q <= 8'h00;
                    end
                end
            end
            if (dwr && bufm && !txf_q) begin
                if (host && en && st_q == ST_IDLE) begin
                    sh_q  <= wd;
                    out_q <= wd[7];
                    st_q  <= ST_SHIFT;
                    div_q <= 8'h00;
                    ld_q  <= 1'b1;
                end else begin
                    txb_q <= wd;
                    txf_q <= 1'b1;
                end
            end
            if (bufm && buffer_wait_for_receive && !act && txf_q && !ld_q) begin
                sh_q  <= txb_q;
                out_q <= txb_q[7];
                txf_q <= 1'b0;
                ld_q  <= 1'b1;
            end
            if (demote) begin
                st_q    <= ST_IDLE;
                sck_out <= 1'b0;
                cnt_q   <= 4'h0;
            end
        end
    end

    // ==========================================
    // receive path and status flags; a hardware set beats a clear
    assign push = d1_q && bufm;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d1_q <= 1'b0; d2_q <= 1'b0; lb_q <= RST_REG8; rxd_q <= RST_REG8;
            td_q <= 1'b0; rxc_q <= 1'b0; txc_q <= 1'b0; ovf_q <= 1'b0;
            rxf_q[0] <= RST_REG8; rxf_q[1] <= RST_REG8; rxn_q <= 2'h0;
        end else if (ce) begin
            d1_q <= done;
            d2_q <= d1_q;
            if (wr_go && ra_q == IDX_FLAG) begin
                if (wd[7]) begin
                    td_q  <= 1'b0;
                    rxc_q <= 1'b0;
                end
                if (wd[6]) txc_q <= 1'b0;
                if (wd[0]) ovf_q <= 1'b0;
            end
            if (done) lb_q <= last;
            if (done && !bufm) begin
                rxd_q <= last;
                td_q  <= 1'b1;
            end
            if (demote) td_q <= 1'b1;
            if (push) rxc_q <= 1'b1;
            if (d2_q && bufm && !txf_q && !(host ? st_q == ST_SHIFT : ld_q))
                txc_q <= 1'b1;
            case ({push, pop})
                2'b10: begin
                    if (rxn_q == 2'h2) begin
                        rxf_q[1] <= lb_q;
                        ovf_q    <= 1'b1;
                    end else begin
                        rxf_q[rxn_q[0]] <= lb_q;
                        rxn_q <= rxn_q + 2'h1;
                    end
                end
                2'b01: begin
                    rxf_q[0] <= rxf_q[1];
                    rxn_q    <= rxn_q - 2'h1;
                end
                2'b11: begin
                    if (rxn_q == 2'h1) begin
                        rxf_q[0] <= lb_q;
                    end else begin
                        rxf_q[0] <= rxf_q[1];
                        rxf_q[1] <= lb_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // pin enables and interrupt request, all registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_oe <= 1'b0; mosi_oe <= 1'b0; miso_oe <= 1'b0;
            mosi_out <= 1'b0; miso_out <= 1'b0; irq <= 1'b0;
        end else if (ce) begin
            sck_oe   <= en && host;
            mosi_oe  <= en && host;
            miso_oe  <= en && !host && pdir_q[B_SOOUT] && !ssn;
            mosi_out <= out_q;
            miso_out <= out_q;
            irq <= (!bufm && td_q && intc_q[B_TDEN])
                 || (bufm && txc_q && intc_q[B_TXCEN])
                 || (bufm && rxc_q && intc_q[B_RXCEN])
                 || (bufm && !txf_q && intc_q[B_DREEN]);
        end
    end

    // ==========================================
    // checks
    a_collide_flag: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        dwr && !bufm && busy |=> wcol_q) else $error("collision flag not set");
    a_rx_load: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        done && !bufm |=> rxd_q == $past(last) && td_q) else $error("rx byte not stored");
    a_irq_done: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        !bufm && td_q && intc_q[B_TDEN] |=> irq) else $error("irq missing");
    a_demote_role: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        demote |=> !host && td_q && st_q == ST_IDLE) else $error("demotion failed");
    a_keep_host: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        host && (seldis || pdir_q[B_SSOUT]) && !(wr_go && ra_q == IDX_CTLA) |=> host)
        else $error("host lost");
    a_ss_halt: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        en && !host && ssn |=> cnt_q == 4'h0) else $error("partial byte kept");
    a_full_drop: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        dwr && bufm && txf_q |=> $stable(txb_q)) else $error("full buffer overwritten");
    a_dre_clear: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        dwr && bufm && !txf_q && !(host && en && st_q == ST_IDLE) |=> txf_q)
        else $error("empty flag stayed high");
    a_rxc_after: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        done && bufm ##1 ce |=> rxc_q) else $error("receive flag late");
    a_miso_off: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        ssn |=> !miso_oe) else $error("miso driven while deselected");
endmodule // spb_core

// ---- spb_pkg.sv ----
package spb_pkg;
    // ==========================================
    // register indices (byte address = index * 4)
    localparam logic [2:0] IDX_CTLA = 3'h0;
    localparam logic [2:0] IDX_CTLB = 3'h1;
    localparam logic [2:0] IDX_INTC = 3'h2;
    localparam logic [2:0] IDX_FLAG = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] IDX_PDIR = 3'h5;
    // ==========================================
    // field positions
    localparam int B_EN     = 0;
    localparam int B_HOST   = 5;
    localparam int B_SELDIS = 2;
    localparam int B_WFR    = 6;
    localparam int B_BUF    = 7;
    localparam int B_TDEN   = 0;
    localparam int B_DREEN  = 5;
    localparam int B_TXCEN  = 6;
    localparam int B_RXCEN  = 7;
    localparam int B_SSOUT  = 0;
    localparam int B_SOOUT  = 1;
    // ==========================================
    // reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam logic [7:0] RST_SHIFT = 8'h00;
    // ==========================================
    // timing: host sck half period in hclk cycles
    localparam int SCK_HALF_DEF = 2;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } spb_state_t;
endpackage

// ---- spb_peer.sv ----
`timescale 1ns/1ps
// ==========================================
// far-side peer: a client while the core hosts, a host while it is a client
module spb_peer (
    input  wire logic hclk,
    input  wire logic sck_out,
    input  wire logic sck_oe,
    input  wire logic mosi_out,
    input  wire logic miso_out,
    input  wire logic miso_oe,
    output logic      sck_in,
    output logic      ss_n_in,
    output logic      mosi_in,
    output logic      miso_in
);
    logic [7:0] csh;
    logic [7:0] hrx;
    logic       s1;
    logic       bt;
    initial begin
        csh     = 8'h00;
        hrx     = 8'h00;
        s1      = 1'b0;
        bt      = 1'b0;
        sck_in  = 1'b0;
        ss_n_in = 1'b1;
        mosi_in = 1'b0;
    end
    // an undriven line shows the inverse, so a stale value cannot pass
    assign miso_in = sck_oe ? csh[7] : ~csh[7];
    always @(posedge hclk) begin
        s1 <= sck_out;
        if (sck_oe && sck_out && !s1) bt <= mosi_out;
        if (sck_oe && !sck_out && s1) csh <= {csh[6:0], bt};
    end
    task automatic load(input logic [7:0] v);
        csh <= v;
    endtask
    task automatic sel(input logic v);
        @(posedge hclk);
        ss_n_in <= v;
        mosi_in <= ~mosi_in;
        repeat (4) @(posedge hclk);
    endtask
    // four hclk a phase: the core samples sck, so phases must stay above two
    task automatic bits(input int n, input logic [7:0] tx);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            sck_in  <= 1'b0;
            mosi_in <= tx[7-i];
            repeat (4) @(posedge hclk);
            sck_in  <= 1'b1;
            hrx     <= {hrx[6:0], miso_oe ? miso_out : 1'bx};
            repeat (3) @(posedge hclk);
        end
        @(posedge hclk);
        sck_in <= 1'b0;
    endtask
endmodule // spb_peer

// ---- spb_core_bench.sv ----
`timescale 1ns/1ps
module spb_core_bench;
    import spb_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, rd_ph, hreadyout, hresp, irq, ce;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sck_in, ss_n_in, mosi_in, miso_in, sck_out, sck_oe;
    logic        mosi_out, mosi_oe, miso_out, miso_oe;
    logic [7:0]  a, b, c, d, last;
    logic [15:0] expq[$];
    logic [15:0] e;
    int          n_errors, checks, seed, i;
    spb_core #(.HALF_DIV(2)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sck_in(sck_in), .ss_n_in(ss_n_in), .mosi_in(mosi_in),
        .miso_in(miso_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq));
    spb_peer P (.hclk(hclk), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
        .miso_out(miso_out), .miso_oe(miso_oe), .sck_in(sck_in), .ss_n_in(ss_n_in),
        .mosi_in(mosi_in), .miso_in(miso_in));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ==========================================
    // checking
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        checks++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask
    // read results are paired with the oldest note of {expected, mask}
    always @(negedge hclk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            e    = expq.pop_front();
            last = hrdata[7:0];
            chk(hrdata[7:0] & e[7:0], e[15:8]);
            chk({7'h0, hresp}, 8'h00);
        end
    end
    task automatic tally_and_finish();
        $display("counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
    // ==========================================
    // bus master
    task automatic bus(input logic [2:0] ix, input logic w, input logic [7:0] dd,
                       input logic [15:0] em);
        logic r;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {27'h0, ix, 2'b00};
        do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (r !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, dd};
        if (!w) begin
            expq.push_back(em);
            rd_ph <= 1'b1;
        end
        do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (r !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] ix, input logic [7:0] dd);
        bus(ix, 1'b1, dd, 16'h0000);
    endtask
    task automatic rd(input logic [2:0] ix, input logic [7:0] x, input logic [7:0] m);
        bus(ix, 1'b0, 8'h00, {x, m});
    endtask
    task automatic poll(input logic [7:0] m);
        int k;
        k = 0;
        do begin rd(IDX_FLAG, 8'h00, 8'h00); k++; end while ((last & m) === 8'h00 && k < 300);
        chk(last & m, m);
    endtask
    // ==========================================
    // scenarios
    initial begin
        seed = 46; hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0;
        hwrite = 1'b0; hwdata = 32'h0; hsize = 3'h2; rd_ph = 1'b0;
        n_errors = 0; checks = 0;
        ce = 1'b1;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_CTLA, 8'h00, 8'hff);
        rd(3'h7, 8'h00, 8'hff);
        wr(IDX_CTLB, 8'h04); wr(IDX_INTC, 8'h01); wr(IDX_CTLA, 8'h21);
        for (i = 0; i < 3; i++) begin
            a = 8'($random(seed)); b = 8'($random(seed)); P.load(b);
            wr(IDX_DATA, a);
            poll(8'h80);
            chk({7'h0, irq}, 8'h01);
            rd(IDX_DATA, b, 8'hff);
            chk(P.csh, a);
            wr(IDX_FLAG, 8'h80); rd(IDX_FLAG, 8'h00, 8'h80);
            chk({7'h0, irq}, 8'h00);
        end
        wr(IDX_DATA, a); wr(IDX_DATA, b);
        poll(8'h80);
        rd(IDX_FLAG, 8'h40, 8'h40);
        wr(IDX_FLAG, 8'hc0);
        $display("test host normal done");
        P.sel(1'b0);
        rd(IDX_CTLA, 8'h20, 8'h20);
        wr(IDX_PDIR, 8'h01); wr(IDX_CTLB, 8'h00);
        rd(IDX_CTLA, 8'h20, 8'h20);
        wr(IDX_PDIR, 8'h02);
        rd(IDX_CTLA, 8'h00, 8'h20);
        rd(IDX_FLAG, 8'h80, 8'h80);
        chk({7'h0, miso_oe}, 8'h01);
        P.sel(1'b1);
        chk({7'h0, miso_oe}, 8'h00);
        wr(IDX_FLAG, 8'hc0); wr(IDX_CTLA, 8'h21);
        rd(IDX_CTLA, 8'h20, 8'h20);
        $display("test multi host done");
        a = 8'($random(seed)); P.load(~a);
        wr(IDX_DATA, a);
        repeat (6) @(posedge hclk);
        ce <= 1'b0;
        @(posedge hclk);
        c = {6'h0, sck_out, mosi_out};
        repeat (10) @(posedge hclk);
        chk({6'h0, sck_out, mosi_out}, c);
        chk({6'h0, sck_oe, mosi_oe}, 8'h03);
        ce <= 1'b1;
        poll(8'h80);
        chk(P.csh, a);
        rd(IDX_DATA, ~a, 8'hff);
        wr(IDX_FLAG, 8'hc0);
        $display("test clock enable done");
        wr(IDX_CTLA, 8'h01);
        a = 8'($random(seed)); b = 8'($random(seed));
        wr(IDX_DATA, a);
        P.sel(1'b0); P.bits(8, b); P.sel(1'b1);
        chk(P.hrx, a);
        rd(IDX_DATA, b, 8'hff);
        rd(IDX_FLAG, 8'h80, 8'hc0);
        wr(IDX_FLAG, 8'hc0); wr(IDX_DATA, a);
        P.sel(1'b0); P.bits(3, b); wr(IDX_DATA, ~a); P.bits(5, b << 3); P.sel(1'b1);
        chk(P.hrx, a);
        rd(IDX_FLAG, 8'hc0, 8'hc0);
        wr(IDX_FLAG, 8'hc0);
        P.sel(1'b0); P.bits(4, a); P.sel(1'b1);
        rd(IDX_FLAG, 8'h00, 8'h80);
        P.sel(1'b0); P.bits(8, b); P.sel(1'b1);
        rd(IDX_DATA, b, 8'hff);
        $display("test client normal done");
        wr(IDX_FLAG, 8'hc0); wr(IDX_CTLB, 8'h80);
        rd(IDX_FLAG, 8'h20, 8'h20);
        a = 8'($random(seed)); c = 8'($random(seed)); d = 8'($random(seed));
        wr(IDX_DATA, a);
        rd(IDX_FLAG, 8'h00, 8'h20);
        wr(IDX_DATA, ~a);
        P.sel(1'b0); P.bits(8, c);
        chk(P.hrx, b);
        P.bits(8, d); P.sel(1'b1);
        chk(P.hrx, a);
        rd(IDX_FLAG, 8'he0, 8'he1);
        rd(IDX_DATA, c, 8'hff);
        rd(IDX_DATA, d, 8'hff);
        $display("test client buffer done");
        wr(IDX_FLAG, 8'hc1); wr(IDX_CTLB, 8'hc4); wr(IDX_CTLA, 8'h21);
        a = 8'($random(seed)); b = 8'($random(seed)); c = 8'($random(seed)); P.load(c);
        wr(IDX_DATA, a); wr(IDX_DATA, b);
        poll(8'h40);
        chk(P.csh, b);
        rd(IDX_DATA, c, 8'hff);
        rd(IDX_DATA, a, 8'hff);
        $display("test host buffer done");
        wr(IDX_CTLA, 8'h01); wr(IDX_CTLB, 8'hc0);
        a = 8'($random(seed)); wr(IDX_DATA, a);
        P.sel(1'b0); P.bits(8, b); P.sel(1'b1);
        chk(P.hrx, a);
        $display("test client wait done");
        tally_and_finish();
    end
endmodule // spb_core_bench
